/* File: core/fspc_pkg.sv */
// Purpose: shared constants and types for the flash self-program control block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package fspc_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] off_mem_size = 8'h00;
    localparam logic [7:0] off_xram_size = 8'h04;
    localparam logic [7:0] off_prog_ctrl = 8'h08;
    localparam logic [7:0] off_fw_addr = 8'h0c;
    localparam logic [7:0] off_command = 8'h10;
    localparam logic [7:0] off_status = 8'h14;
    localparam logic [7:0] off_baud = 8'h18;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [7:0] rst_mem_size = 8'hcf;
    localparam logic [7:0] rst_xram_size = 8'h0c;
    localparam logic rst_write_inhibit = 1'b1;
    localparam int pos_mode_low = 0;
    localparam int pos_addr_source = 1;
    localparam int pos_write_inhibit = 2;
    localparam int pos_cmd_write = 0;
    localparam int pos_cmd_erase = 1;

    // ****************************************
    // timing: one byte of 0x00 is low for start plus eight data bits
    // ****************************************
    localparam int low_bit_times = 9;

    // status word fields
    typedef struct packed {
        logic baud_valid;
        logic onboard_mode;
        logic start_refused;
        logic busy;
        logic addr_from_fw;
    } fspc_status_t;
endpackage

/* File: core/fspc_baud_meas.sv */
// Purpose: measures the reset command on the serial line to derive bit length
// Assumes: rxd synchronous to pclk, idle high; reset command byte is all zeros
// Notes: bit length = low time / 9, found by repeated subtraction
`timescale 1ns/1ns
module fspc_baud_meas #(
    parameter int cnt_w = 20
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // control
    input wire logic arm,
    input wire logic rxd,
    // result
    output logic [cnt_w-1:0] bit_cycles,
    output logic valid
);
    typedef enum logic [4:0] {
        st_idle = 5'b00001,
        st_wait_low = 5'b00010,
        st_measure = 5'b00100,
        st_divide = 5'b01000,
        st_done = 5'b10000
    } fspc_meas_state_t;

    localparam logic [cnt_w-1:0] div_step = cnt_w'(fspc_pkg::low_bit_times);

    fspc_meas_state_t state, next_state;
    logic [cnt_w-1:0] width, next_width;
    logic [cnt_w-1:0] quot, next_quot;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        next_state = state;
        next_width = width;
        next_quot = quot;
        case (state)
            st_idle: begin
                if (arm) begin
                    next_state = st_wait_low;
                end
            end
            st_wait_low: begin
                next_width = '0;
                if (!rxd) begin
                    next_state = st_measure;
                    next_width = cnt_w'(1);
                end
            end
            st_measure: begin
                if (rxd) begin
                    next_state = st_divide;
                    next_quot = '0;
                end else if (width != '1) begin
                    next_width = width + cnt_w'(1); // saturate on a stuck-low line
                end
            end
            st_divide: begin
                // serial divide keeps the area small; takes width/9 + 1 cycles
                if (width >= div_step) begin
                    next_width = width - div_step;
                    next_quot = quot + cnt_w'(1);
                end else begin
                    next_state = st_done;
                end
            end
            st_done: begin
                next_state = st_done;
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
            width <= '0;
            quot <= '0;
            bit_cycles <= '0;
            valid <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            width <= next_width;
            quot <= next_quot;
            bit_cycles <= (next_state == st_done) ? next_quot : bit_cycles;
            valid <= (next_state == st_done);
        end
    end
endmodule // fspc_baud_meas

/* File: core/fspc_ctrl.sv */
// Purpose: register file and control around the on-chip flash array
// Assumes: all pins synchronous to pclk; apb master holds requests until pready
// Notes: on-board mode is latched until reset once a mode-entry pulse is seen
//
// Behaviour
// - the internal memory size register resets to cfh.
// - the expansion ram size register resets to 0ch and software then writes 0ah to it.
// - after a mode-entry pin pulse the receive bit length is measured from the reset command.
// - flash address comes from the cpu bus when the source bit is 0, else from firmware.
// - in on-board mode both self-program mode bits are ignored.
`timescale 1ns/1ns
module fspc_ctrl #(
    parameter int addr_w = 17,
    parameter int baud_w = 20
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // programming pins
    input wire logic flash_mode_entry_pin,
    input wire logic programming_serial_rxd,
    // flash array side
    input wire logic [addr_w-1:0] cpu_addr,
    input wire logic flash_op_done,
    output logic [addr_w-1:0] flash_addr,
    output logic flash_write_start,
    output logic flash_erase_start,
    output logic flash_busy,
    // mode and size selections
    output logic [7:0] internal_memory_size_select,
    output logic [7:0] expansion_ram_size_select,
    output logic onboard_mode,
    output logic [baud_w-1:0] baud_bit_cycles,
    output logic baud_valid
);
    // ****************************************
    // register state
    // ****************************************
    logic [7:0] next_mem_size, next_xram_size;
    logic self_program_mode_low, next_mode_low;
    logic self_program_address_source, next_addr_source;
    logic flash_write_inhibit, next_write_inhibit;
    logic [addr_w-1:0] fw_addr, next_fw_addr;
    logic start_refused, next_start_refused;
    logic next_busy, next_write_start, next_erase_start;
    logic next_onboard, entry_seen, next_entry_seen;
    logic [addr_w-1:0] next_flash_addr;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic acc, wr, rd, mapped;
    logic cmd_write, cmd_erase, refuse;
    logic [baud_w-1:0] meas_cycles;
    logic meas_valid;
    fspc_pkg::fspc_status_t status;

    // ****************************************
    // apb decode
    // ****************************************
    // a request completes on the edge where pready is seen high
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign rd = psel && penable && !pready && !pwrite;
    always_comb begin
        case (paddr)
            fspc_pkg::off_mem_size, fspc_pkg::off_xram_size, fspc_pkg::off_prog_ctrl,
            fspc_pkg::off_fw_addr, fspc_pkg::off_command, fspc_pkg::off_status,
            fspc_pkg::off_baud: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // status word seen by software
    always_comb begin
        status.baud_valid = meas_valid;
        status.onboard_mode = onboard_mode;
        status.start_refused = start_refused;
        status.busy = flash_busy;
        status.addr_from_fw = self_program_address_source && !onboard_mode;
    end

    // ****************************************
    // bus answer: one wait state, data staged with pready
    // ****************************************
    always_comb begin
        next_pready = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !mapped;
        next_prdata = prdata;
        if (rd) begin
            case (paddr)
                fspc_pkg::off_mem_size: next_prdata = {24'h000000, internal_memory_size_select};
                fspc_pkg::off_xram_size: next_prdata = {24'h000000, expansion_ram_size_select};
                fspc_pkg::off_prog_ctrl: next_prdata = {29'h00000000, flash_write_inhibit,
                    self_program_address_source, self_program_mode_low};
                fspc_pkg::off_fw_addr: next_prdata = 32'(fw_addr);
                fspc_pkg::off_status: next_prdata = 32'(status);
                fspc_pkg::off_baud: next_prdata = 32'(meas_cycles);
                default: next_prdata = 32'h00000000; // command reads as zero
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_comb begin
        next_mem_size = internal_memory_size_select;
        next_xram_size = expansion_ram_size_select;
        next_mode_low = self_program_mode_low;
        next_addr_source = self_program_address_source;
        next_write_inhibit = flash_write_inhibit;
        next_fw_addr = fw_addr;
        if (wr) begin
            case (paddr)
                fspc_pkg::off_mem_size: next_mem_size = pwdata[7:0];
                fspc_pkg::off_xram_size: next_xram_size = pwdata[7:0];
                fspc_pkg::off_prog_ctrl: begin
                    // mode bits are software's to time; no fetch guard here
                    next_mode_low = pwdata[fspc_pkg::pos_mode_low];
                    next_addr_source = pwdata[fspc_pkg::pos_addr_source];
                    next_write_inhibit = pwdata[fspc_pkg::pos_write_inhibit];
                end
                fspc_pkg::off_fw_addr: next_fw_addr = pwdata[addr_w-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_memory_size_select <= fspc_pkg::rst_mem_size;
            expansion_ram_size_select <= fspc_pkg::rst_xram_size;
            self_program_mode_low <= 1'b0;
            self_program_address_source <= 1'b0;
            flash_write_inhibit <= fspc_pkg::rst_write_inhibit;
            fw_addr <= '0;
        end else if (clk_en) begin
            internal_memory_size_select <= next_mem_size;
            expansion_ram_size_select <= next_xram_size;
            self_program_mode_low <= next_mode_low;
            self_program_address_source <= next_addr_source;
            flash_write_inhibit <= next_write_inhibit;
            fw_addr <= next_fw_addr;
        end
    end

    // ****************************************
    // flash operation start, busy and refusal
    // ****************************************
    assign cmd_write = wr && (paddr == fspc_pkg::off_command) &&
        pwdata[fspc_pkg::pos_cmd_write];
    assign cmd_erase = wr && (paddr == fspc_pkg::off_command) &&
        pwdata[fspc_pkg::pos_cmd_erase] && !pwdata[fspc_pkg::pos_cmd_write];
    // a start while inhibited or already busy never reaches the array
    assign refuse = (cmd_write || cmd_erase) && (flash_write_inhibit || flash_busy);
    always_comb begin
        next_write_start = cmd_write && !refuse;
        next_erase_start = cmd_erase && !refuse;
        next_busy = flash_busy;
        if (next_write_start || next_erase_start) begin
            next_busy = 1'b1;
        end else if (flash_op_done) begin
            next_busy = 1'b0;
        end
        next_start_refused = start_refused;
        // reading status clears the sticky flag; a new refusal in that cycle wins
        if (rd && (paddr == fspc_pkg::off_status)) begin
            next_start_refused = 1'b0;
        end
        if (refuse) begin
            next_start_refused = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_write_start <= 1'b0;
            flash_erase_start <= 1'b0;
            flash_busy <= 1'b0;
            start_refused <= 1'b0;
        end else if (clk_en) begin
            flash_write_start <= next_write_start;
            flash_erase_start <= next_erase_start;
            flash_busy <= next_busy;
            start_refused <= next_start_refused;
        end
    end

    // ****************************************
    // on-board mode entry and address source
    // ****************************************
    always_comb begin
        next_entry_seen = entry_seen || flash_mode_entry_pin;
        // a full pulse (high then low again) enters on-board mode until reset
        next_onboard = onboard_mode || (entry_seen && !flash_mode_entry_pin);
        // on-board mode takes the cpu bus whatever the mode bits say
        if (self_program_address_source && !onboard_mode) begin
            next_flash_addr = fw_addr;
        end else begin
            next_flash_addr = cpu_addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_seen <= 1'b0;
            onboard_mode <= 1'b0;
            flash_addr <= '0;
            baud_bit_cycles <= '0;
            baud_valid <= 1'b0;
        end else if (clk_en) begin
            entry_seen <= next_entry_seen;
            onboard_mode <= next_onboard;
            flash_addr <= next_flash_addr;
            baud_bit_cycles <= meas_cycles;
            baud_valid <= meas_valid;
        end
    end

    // ****************************************
    // receive bit length from the reset command
    // ****************************************
    fspc_baud_meas #(
        .cnt_w(baud_w)
    ) u_meas (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .arm(onboard_mode),
        .rxd(programming_serial_rxd),
        .bit_cycles(meas_cycles),
        .valid(meas_valid)
    );
endmodule // fspc_ctrl

/* File: dv/fspc_ctrl_asserts.sv */
// Purpose: port-level checks on the flash self-program control block
// Assumes: one pclk domain, presetn asynchronous active low
// Notes: register contents behind the bus are judged by the bench
`timescale 1ns/1ns
module fspc_ctrl_asserts #(
    parameter int addr_w = 17
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // flash and mode
    input wire logic [addr_w-1:0] cpu_addr,
    input wire logic [addr_w-1:0] flash_addr,
    input wire logic flash_write_start,
    input wire logic flash_erase_start,
    input wire logic flash_busy,
    input wire logic [7:0] internal_memory_size_select,
    input wire logic onboard_mode,
    input wire logic baud_valid
);
    // ********
    // helpers
    // ********
    // a command write completing at this edge
    wire cmd_wr = psel && penable && pready && pwrite && (paddr == fspc_pkg::off_command);
    wire any_start = flash_write_start || flash_erase_start;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_start; any_start && flash_busy; endsequence
    sequence s_start_end; !any_start && flash_busy; endsequence
    // ********
    // properties
    // ********
    property p_ready_rise; s_access |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_qual; pslverr |-> pready; endproperty
    property p_mem_reset; $rose(presetn) |-> internal_memory_size_select == 8'hcf; endproperty
    property p_write_cause; flash_write_start |-> $past(cmd_wr && pwdata[0] && !flash_busy);
    endproperty
    property p_erase_cause;
        flash_erase_start |-> $past(cmd_wr && pwdata[1:0] == 2'b10 && !flash_busy);
    endproperty
    property p_start_pulse; any_start |-> s_start ##1 s_start_end; endproperty
    property p_onboard_addr; $past(onboard_mode) |-> flash_addr == $past(cpu_addr); endproperty
    property p_onboard_sticky; onboard_mode |=> onboard_mode; endproperty
    property p_baud_after; baud_valid |-> onboard_mode; endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("pready late");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    a_err_qual: assert property (p_err_qual) else $error("pslverr without pready");
    a_mem_reset: assert property (p_mem_reset) else $error("mem size reset");
    a_write_cause: assert property (p_write_cause) else $error("bad write start");
    a_erase_cause: assert property (p_erase_cause) else $error("bad erase start");
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse shape");
    a_onboard_addr: assert property (p_onboard_addr) else $error("onboard addr");
    a_onboard_sticky: assert property (p_onboard_sticky) else $error("onboard lost");
    a_baud_after: assert property (p_baud_after) else $error("baud before entry");
endmodule // fspc_ctrl_asserts

bind fspc_ctrl fspc_ctrl_asserts #(.addr_w(addr_w)) fspc_ctrl_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .cpu_addr(cpu_addr), .flash_addr(flash_addr), .flash_write_start(flash_write_start),
    .flash_erase_start(flash_erase_start), .flash_busy(flash_busy),
    .internal_memory_size_select(internal_memory_size_select),
    .onboard_mode(onboard_mode), .baud_valid(baud_valid)
);

/* File: dv/fspc_prog_model.sv */
// Purpose: external flash programmer on the mode pin and serial line
// Assumes: line idle high through a pull-up
// Notes: sends only the entry pulse and one all-zero reset command
`timescale 1ns/1ns
module fspc_prog_model #(
    parameter int bit_len = 16,
    parameter int gap = 10
) (
    // clock and trigger
    input wire logic pclk,
    input wire logic go,
    // pins
    output logic mode_pin,
    output logic rxd
);
    // pulse the entry pin first, then the reset command byte
    initial begin
        mode_pin = 1'b0;
        rxd = 1'b1;
        @(posedge go);
        @(posedge pclk);
        mode_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        mode_pin <= 1'b0;
        repeat (gap) @(posedge pclk);
        rxd <= 1'b0;
        repeat (9 * bit_len) @(posedge pclk);
        rxd <= 1'b1;
    end
endmodule // fspc_prog_model

/* File: dv/fspc_ctrl_tb_top.sv */
// Purpose: self-checking bench for the flash self-program control block
// Assumes: apb master waits for pready; read data taken at the edge that sees it high
// Notes: clk_en held high, stalls are not exercised
`timescale 1ns/1ns
module fspc_ctrl_tb_top;
    localparam int bit_len = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [16:0] cpu_addr = 17'h00123;
    logic flash_op_done = 1'b0;
    logic go = 1'b0;
    logic mode_pin, rxd, pready, pslverr, err;
    logic [31:0] prdata, rd;
    logic [16:0] flash_addr;
    logic wr_start, er_start, busy, onboard_mode, baud_valid;
    logic [7:0] mem_size, xram_size;
    logic [19:0] baud;
    int miscompares = 0;
    int n_compared = 0;
    int n_wr = 0;
    int n_er = 0;
    int n;

    // half period of the 50 ns clock
    always #25 pclk = ~pclk;

    fspc_ctrl fspc_ctrl_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_mode_entry_pin(mode_pin),
        .programming_serial_rxd(rxd), .cpu_addr(cpu_addr), .flash_op_done(flash_op_done),
        .flash_addr(flash_addr), .flash_write_start(wr_start), .flash_erase_start(er_start),
        .flash_busy(busy), .internal_memory_size_select(mem_size),
        .expansion_ram_size_select(xram_size), .onboard_mode(onboard_mode),
        .baud_bit_cycles(baud), .baud_valid(baud_valid));
    fspc_prog_model #(.bit_len(bit_len)) fspc_prog_model_i (.pclk(pclk), .go(go),
        .mode_pin(mode_pin), .rxd(rxd));

    // count start pulses mid-cycle, away from the launching edge
    always @(negedge pclk) begin
        if (wr_start === 1'b1) n_wr++;
        if (er_start === 1'b1) n_er++;
    end

    task automatic close_out;
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            miscompares++;
        end
    endtask

    task automatic give_up;
        $display("[ERR] %0t wait ran out", $time);
        miscompares++;
        close_out();
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is read at the edge itself, before that edge's updates land
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) give_up();
        rd = prdata;
        err = pslverr;
        // release only after the completing edge, then let one edge pass
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // one-cycle completion pulse from the flash array
    task automatic op_done;
        flash_op_done <= 1'b1;
        @(posedge pclk);
        flash_op_done <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, fspc_pkg::off_mem_size, 32'h0);
        chk(rd, 32'h000000cf);
        chk({24'h0, mem_size}, 32'h000000cf);
        apb(1'b0, fspc_pkg::off_xram_size, 32'h0);
        chk(rd, 32'h0000000c);
        apb(1'b1, fspc_pkg::off_xram_size, 32'h0000000a);
        chk({24'h0, xram_size}, 32'h0000000a);
        apb(1'b0, fspc_pkg::off_prog_ctrl, 32'h0);
        chk(rd, 32'h00000004);
        // a start while inhibited must be refused and flagged
        apb(1'b1, fspc_pkg::off_command, 32'h00000001);
        apb(1'b0, fspc_pkg::off_status, 32'h0);
        chk(rd & 32'h00000004, 32'h00000004);
        chk(n_wr, 32'h0);
        apb(1'b1, fspc_pkg::off_prog_ctrl, 32'h0);
        apb(1'b1, fspc_pkg::off_command, 32'h00000001);
        chk({n_wr[30:0], busy}, 32'h00000003);
        apb(1'b1, fspc_pkg::off_command, 32'h00000002);
        apb(1'b0, fspc_pkg::off_status, 32'h0);
        chk({rd[2:1], n_er[0]}, 32'h00000006);
        op_done();
        chk(busy, 1'b0);
        apb(1'b1, fspc_pkg::off_command, 32'h00000002);
        chk(n_er, 32'h1);
        op_done();
        // address source switch, inhibit back on for normal running
        apb(1'b1, fspc_pkg::off_fw_addr, 32'h0001abcd);
        chk(flash_addr, 17'h00123);
        apb(1'b1, fspc_pkg::off_prog_ctrl, 32'h00000006);
        repeat (2) @(posedge pclk);
        chk(flash_addr, 17'h1abcd);
        apb(1'b0, fspc_pkg::off_status, 32'h0);
        chk(rd & 32'h00000001, 32'h00000001);
        // unmapped place: error, write dropped, reads zero
        apb(1'b1, 8'h1c, 32'hffffffff);
        chk(err, 1'b1);
        apb(1'b0, 8'h1c, 32'h0);
        chk({rd[30:0], err}, 32'h00000001);
        // on-board entry and baud measurement
        go <= 1'b1;
        n = 0;
        while (baud_valid !== 1'b1 && n < 600) begin
            @(negedge pclk);
            n++;
        end
        if (baud_valid !== 1'b1) give_up();
        @(posedge pclk);
        cpu_addr <= 17'h0a5a5;
        repeat (2) @(posedge pclk);
        chk(flash_addr, 17'h0a5a5);
        chk(onboard_mode, 1'b1);
        chk(baud >= bit_len - 1 && baud <= bit_len + 1, 1'b1);
        apb(1'b0, fspc_pkg::off_baud, 32'h0);
        chk(rd, {12'h0, baud});
        apb(1'b0, fspc_pkg::off_status, 32'h0);
        // source bit is still 1, but on-board mode must hide it from status
        chk(rd & 32'h00000019, 32'h00000018);
        close_out();
    end
endmodule // fspc_ctrl_tb_top
